/* sbp_pkg.sv */
// constants and types shared by the parameter bank priority selector
package sbp_pkg;
	// ==========================================================
	// bank and stamp geometry
	localparam int NUM_BANKS = 8;
	localparam int BANK_IDX_W = 3;
	localparam int STAMP_W = 32;
	localparam int USED_W = 4;
	// ==========================================================
	// active-bank reset value and clamp limits of the used-bank count
	localparam logic [NUM_BANKS-1:0] ACTIVE_RST = 8'h01;
	localparam logic [USED_W-1:0] USED_MIN = 4'h1;
	localparam logic [USED_W-1:0] USED_MAX = 4'h8;
	// ==========================================================
	// bit positions of the single-source event pairs
	localparam int EV_REMOTE = 0;
	localparam int EV_LOCAL = 1;
	localparam int EV_FORCE = 2;
	localparam int EV_NOTCFG = 3;
	localparam int EV_FORCEFAIL = 4;
	localparam int EV_LOWER = 5;
	localparam int EV_W = 6;
	// ==========================================================
	// selection mode
	typedef enum logic {
		SBP_NORMAL,
		SBP_FORCED
	} sbp_mode_t;
endpackage

/* sbp_edge.sv */
// rise and fall detector for a vector of levels
`timescale 1ns/1ps
module sbp_edge #(
	parameter int W = 8
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [W-1:0] lvl_in,
	output logic [W-1:0] rise_out,
	output logic [W-1:0] fall_out
);
	logic [W-1:0] prev_q;

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			prev_q <= '0;
		end else begin
			prev_q <= lvl_in;
		end
	end

	assign rise_out = lvl_in & ~prev_q;
	assign fall_out = ~lvl_in & prev_q;
endmodule

/* sbp_stamp.sv */
// free-running time base for event stamping
`timescale 1ns/1ps
module sbp_stamp #(
	parameter int W = 32
) (
	input wire logic clk_in,
	input wire logic rst_in,
	output logic [W-1:0] stamp_out
);
	// wraps silently; consumers must handle rollover
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			stamp_out <= '0;
		end else begin
			stamp_out <= stamp_out + 1'b1;
		end
	end
endmodule

/* sbp_bank_select.sv */
// priority selector for the active parameter bank with event output
//
// Functional notes
// RQ1: eight bank request inputs, each usable as pulse or static level.
// RQ2: fixed priority, bank 1 highest down to bank 8 lowest.
// RQ3: static bank 1 request makes every other request ignored.
// RQ4: static intermediate request ignores lower banks, still honours higher.
// RQ5: static bank 8 request blocks nothing.
// RQ6: every event is output with a time stamp.
// RQ7: events for bank enable/disable, request edges, active edges.
// RQ8: on/off events for remote, local and forced-change requests.
// RQ9: request to unconfigured bank is rejected, fail event raised then cleared.
// RQ10: request refused by forcing raises fail event, off event when over.
// RQ11: request losing to held higher static raises fail event and off.
// RQ12: pulse-selected bank stays active until another bank is requested; code also falls back to bank 1 when the active bank becomes unconfigured.
// RQ13: forced mode overrides automatic control until disabled.
// RQ14: simultaneous pulse requests select the highest-priority bank.
`timescale 1ns/1ps
module sbp_bank_select import sbp_pkg::*; #(
	parameter int STAMP_WIDTH = STAMP_W
) (
	input wire logic CLK_IN,
	input wire logic RST_IN,
	input wire logic [NUM_BANKS-1:0] BANK_REQ_IN,
	input wire logic [NUM_BANKS-1:0] BANK_STATIC_IN,
	input wire logic [USED_W-1:0] USED_BANKS_IN,
	input wire logic REMOTE_REQ_IN,
	input wire logic [BANK_IDX_W-1:0] REMOTE_BANK_IN,
	input wire logic LOCAL_REQ_IN,
	input wire logic [BANK_IDX_W-1:0] LOCAL_BANK_IN,
	input wire logic FORCE_EN_IN,
	input wire logic [USED_W-1:0] FORCE_BANK_IN,
	output logic [NUM_BANKS-1:0] ACTIVE_BANK_OUT,
	output logic FORCED_OUT,
	output logic EVT_VALID_OUT,
	output logic [STAMP_WIDTH-1:0] EVT_STAMP_OUT,
	output logic [NUM_BANKS-1:0] EVT_EN_ON_OUT,
	output logic [NUM_BANKS-1:0] EVT_EN_OFF_OUT,
	output logic [NUM_BANKS-1:0] EVT_REQ_ON_OUT,
	output logic [NUM_BANKS-1:0] EVT_REQ_OFF_OUT,
	output logic [NUM_BANKS-1:0] EVT_ACT_ON_OUT,
	output logic [NUM_BANKS-1:0] EVT_ACT_OFF_OUT,
	output logic [EV_W-1:0] EVT_MISC_ON_OUT,
	output logic [EV_W-1:0] EVT_MISC_OFF_OUT
);
	// ==========================================================
	// decoding helpers
	function automatic logic [NUM_BANKS-1:0] bank_onehot(
		input logic [BANK_IDX_W-1:0] idx,
		input logic en
	);
		bank_onehot = en ? (8'h01 << idx) : 8'h00;
	endfunction

	function automatic logic [BANK_IDX_W-1:0] first_set(
		input logic [NUM_BANKS-1:0] vec
	);
		first_set = 3'h0;
		for (int k = NUM_BANKS - 1; k >= 0; k--) begin
			if (vec[k]) begin
				first_set = BANK_IDX_W'(k);
			end
		end
	endfunction

	// ==========================================================
	// declarations
	sbp_mode_t mode_q;
	logic forced;
	logic [NUM_BANKS-1:0] active_q;
	logic [NUM_BANKS-1:0] active_d;
	logic [USED_W-1:0] used_c;
	logic [NUM_BANKS-1:0] cfg;
	logic [NUM_BANKS-1:0] hold;
	logic [NUM_BANKS-1:0] blocked;
	logic [NUM_BANKS-1:0] req_rise;
	logic [NUM_BANKS-1:0] req_fall;
	logic [NUM_BANKS-1:0] rem_oh;
	logic [NUM_BANKS-1:0] loc_oh;
	logic [NUM_BANKS-1:0] raw;
	logic [NUM_BANKS-1:0] cand;
	logic [NUM_BANKS-1:0] pick_oh;
	logic [NUM_BANKS-1:0] force_oh;
	logic force_ok;
	logic force_bad;
	logic [NUM_BANKS-1:0] cfg_rise;
	logic [NUM_BANKS-1:0] cfg_fall;
	logic [EV_W-1:0] lvl;
	logic [EV_W-1:0] lvl_rise;
	logic [EV_W-1:0] lvl_fall;
	logic [STAMP_WIDTH-1:0] stamp;
	logic [NUM_BANKS-1:0] act_on_d;
	logic [NUM_BANKS-1:0] act_off_d;
	logic any_evt;

	// ==========================================================
	// configuration and blocking
	// out-of-range counts are clamped rather than rejected
	assign used_c = (USED_BANKS_IN < USED_MIN) ? USED_MIN :
		(USED_BANKS_IN > USED_MAX) ? USED_MAX : USED_BANKS_IN;
	assign forced = (mode_q == SBP_FORCED);

	genvar gi;
	generate
		for (gi = 0; gi < NUM_BANKS; gi++) begin : g_bank
			assign cfg[gi] = (USED_W'(gi) < used_c);
			if (gi == NUM_BANKS - 1) begin : g_last
				assign hold[gi] = 1'b0; // RQ5
			end else begin : g_mid
				// RQ1
				assign hold[gi] = BANK_REQ_IN[gi] & BANK_STATIC_IN[gi] &
					cfg[gi];
			end
			if (gi == 0) begin : g_top
				assign blocked[gi] = 1'b0;
			end else begin : g_low
				assign blocked[gi] = |hold[gi-1:0]; // RQ3 RQ4
			end
		end
	endgenerate

	// ==========================================================
	// request gathering and priority pick
	assign rem_oh = bank_onehot(REMOTE_BANK_IN, REMOTE_REQ_IN);
	assign loc_oh = bank_onehot(LOCAL_BANK_IN, LOCAL_REQ_IN);
	// a static level keeps requesting every cycle, so it wins back
	// the selection as soon as a higher pulse has passed
	assign raw = req_rise | (BANK_REQ_IN & BANK_STATIC_IN) | rem_oh | loc_oh;
	assign cand = raw & cfg & ~blocked; // RQ3 RQ4 RQ5
	assign pick_oh = bank_onehot(first_set(cand), |cand); // RQ2 RQ14

	assign force_ok = (FORCE_BANK_IN != 4'h0) && (FORCE_BANK_IN <= used_c);
	assign force_bad = (FORCE_BANK_IN != 4'h0) && !force_ok;
	assign force_oh = bank_onehot(BANK_IDX_W'(FORCE_BANK_IN - 4'h1),
		force_ok);

	always_comb begin
		active_d = active_q;
		if ((active_q & cfg) == 8'h00) begin
			active_d = ACTIVE_RST;
		end else if (forced) begin
			if (force_ok) begin
				active_d = force_oh; // RQ13
			end
		end else if (|cand) begin
			active_d = pick_oh; // RQ2 RQ12 RQ14
		end
	end

	// ==========================================================
	// mode and active bank state
	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			mode_q <= SBP_NORMAL;
		end else begin
			mode_q <= FORCE_EN_IN ? SBP_FORCED : SBP_NORMAL; // RQ13
		end
	end

	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			active_q <= ACTIVE_RST;
		end else begin
			active_q <= active_d; // RQ12
		end
	end

	assign ACTIVE_BANK_OUT = active_q;
	assign FORCED_OUT = forced;

	// ==========================================================
	// edge detection of inputs and fail conditions
	sbp_edge #(.W(NUM_BANKS)) u_req_edge (
		.clk_in(CLK_IN),
		.rst_in(RST_IN),
		.lvl_in(BANK_REQ_IN),
		.rise_out(req_rise),
		.fall_out(req_fall)
	);

	sbp_edge #(.W(NUM_BANKS)) u_cfg_edge (
		.clk_in(CLK_IN),
		.rst_in(RST_IN),
		.lvl_in(cfg),
		.rise_out(cfg_rise),
		.fall_out(cfg_fall)
	);

	always_comb begin
		lvl = '0;
		lvl[EV_REMOTE] = REMOTE_REQ_IN; // RQ8
		lvl[EV_LOCAL] = LOCAL_REQ_IN; // RQ8
		lvl[EV_FORCE] = FORCE_EN_IN; // RQ8
		// clears again once the offending request is gone
		lvl[EV_NOTCFG] = forced ? force_bad : |(raw & ~cfg); // RQ9
		lvl[EV_FORCEFAIL] = forced & (|BANK_REQ_IN | REMOTE_REQ_IN |
			LOCAL_REQ_IN); // RQ10
		lvl[EV_LOWER] = ~forced & |(raw & cfg & blocked); // RQ11
	end

	sbp_edge #(.W(EV_W)) u_lvl_edge (
		.clk_in(CLK_IN),
		.rst_in(RST_IN),
		.lvl_in(lvl),
		.rise_out(lvl_rise),
		.fall_out(lvl_fall)
	);

	sbp_stamp #(.W(STAMP_WIDTH)) u_stamp (
		.clk_in(CLK_IN),
		.rst_in(RST_IN),
		.stamp_out(stamp)
	);

	// ==========================================================
	// event output, one flag per event, all sharing one stamp
	assign act_on_d = active_d & ~active_q;
	assign act_off_d = ~active_d & active_q;
	assign any_evt = |{cfg_rise[NUM_BANKS-1:1], cfg_fall[NUM_BANKS-1:1],
		req_rise, req_fall, act_on_d, act_off_d, lvl_rise, lvl_fall};

	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			EVT_VALID_OUT <= 1'b0;
			EVT_STAMP_OUT <= '0;
			EVT_EN_ON_OUT <= '0;
			EVT_EN_OFF_OUT <= '0;
			EVT_REQ_ON_OUT <= '0;
			EVT_REQ_OFF_OUT <= '0;
			EVT_ACT_ON_OUT <= '0;
			EVT_ACT_OFF_OUT <= '0;
			EVT_MISC_ON_OUT <= '0;
			EVT_MISC_OFF_OUT <= '0;
		end else begin
			EVT_VALID_OUT <= any_evt;
			EVT_STAMP_OUT <= stamp; // RQ6
			// bank 1 can never be disabled, so it has no enable events
			EVT_EN_ON_OUT <= {cfg_rise[NUM_BANKS-1:1], 1'b0}; // RQ7
			EVT_EN_OFF_OUT <= {cfg_fall[NUM_BANKS-1:1], 1'b0}; // RQ7
			EVT_REQ_ON_OUT <= req_rise; // RQ7
			EVT_REQ_OFF_OUT <= req_fall; // RQ7
			EVT_ACT_ON_OUT <= act_on_d; // RQ7
			EVT_ACT_OFF_OUT <= act_off_d; // RQ7
			EVT_MISC_ON_OUT <= lvl_rise; // RQ8 RQ9 RQ10 RQ11
			EVT_MISC_OFF_OUT <= lvl_fall; // RQ8 RQ9 RQ10 RQ11
		end
	end

	// ==========================================================
	// assertions
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (RST_IN);

	a_bank_one_static: assert property ( // RQ3
		!forced && BANK_REQ_IN[0] && BANK_STATIC_IN[0]
		|=> ACTIVE_BANK_OUT == 8'h01)
		else $error("static bank 1 request did not hold selection");

	a_mid_static_block: assert property ( // RQ4
		!forced && hold[1] && ((active_q & cfg) != 8'h00)
		|=> ACTIVE_BANK_OUT[7:2] == 6'h00)
		else $error("bank below held static bank 2 became active");

	a_last_no_block: assert property ( // RQ5
		!forced && BANK_REQ_IN[7] && BANK_STATIC_IN[7] && req_rise[5] &&
		cfg[5] && !(|hold[4:0]) && ((active_q & cfg) != 8'h00)
		|=> ACTIVE_BANK_OUT == 8'h20)
		else $error("static bank 8 blocked a bank 6 pulse");

	a_priority_pick: assert property ( // RQ2
		!forced && (|cand) && ((active_q & cfg) != 8'h00)
		|=> ACTIVE_BANK_OUT == $past(cand & ~(cand - 8'h01)))
		else $error("selected bank is not the highest requested");

	a_pulse_latches: assert property ( // RQ12
		!forced && !(|cand) && ((active_q & cfg) != 8'h00)
		|=> $stable(ACTIVE_BANK_OUT))
		else $error("active bank changed without a request");

	a_force_override: assert property ( // RQ13
		forced && force_ok && ((active_q & cfg) != 8'h00)
		|=> ACTIVE_BANK_OUT == $past(force_oh) &&
		FORCED_OUT == $past(FORCE_EN_IN))
		else $error("forced bank not applied");

	a_act_event: assert property ( // RQ7
		EVT_ACT_ON_OUT == (ACTIVE_BANK_OUT & ~$past(ACTIVE_BANK_OUT)))
		else $error("active-on event does not match selection change");

	a_stamp_tag: assert property ( // RQ6
		EVT_VALID_OUT |-> EVT_STAMP_OUT == $past(stamp))
		else $error("event stamp is not the cause cycle time");

	a_force_edge: assert property ( // RQ8
		$rose(FORCE_EN_IN) |=> EVT_MISC_ON_OUT[EV_FORCE] &&
		FORCED_OUT)
		else $error("forced-change on event missing");

	a_notcfg_fail: assert property ( // RQ9
		!forced && $rose(|(raw & ~cfg)) |=> EVT_MISC_ON_OUT[EV_NOTCFG])
		else $error("unconfigured request did not raise fail event");

	a_forcefail_evt: assert property ( // RQ10
		$rose(lvl[EV_FORCEFAIL]) |=> EVT_MISC_ON_OUT[EV_FORCEFAIL] &&
		EVT_VALID_OUT)
		else $error("refusal under forcing not reported");

	a_lower_fail: assert property ( // RQ11
		$fell(lvl[EV_LOWER]) |=> EVT_MISC_OFF_OUT[EV_LOWER])
		else $error("lower-priority fail off event missing");

	c_pulse_switch: cover property (
		!forced && req_rise[4] ##1 ACTIVE_BANK_OUT == 8'h10);
	c_static_hold: cover property (
		hold[1] && req_rise[4] ##1 EVT_MISC_ON_OUT[EV_LOWER]);
	c_forced_sel: cover property (
		forced && force_ok ##1 EVT_ACT_ON_OUT != 8'h00);
endmodule

/* sbp_req_src.sv */
// request source model standing in for the digital input stage
`timescale 1ns/1ps
module sbp_req_src (
	input wire logic clk_in,
	output logic [7:0] req_out,
	output logic [7:0] static_out
);
	initial begin
		req_out = 8'h00;
		static_out = 8'h00;
	end
	// ==========================================
	// levels change 1 ns after the edge, never on it
	task automatic step();
		@(posedge clk_in);
		#1;
	endtask
	task automatic hold(input logic [7:0] m, input logic lvl);
		if (lvl) begin
			req_out |= m;
			static_out |= m;
		end else begin
			req_out &= ~m;
			static_out &= ~m;
		end
	endtask
	// one high cycle, then low long enough to count as a new pulse
	task automatic pulse(input logic [7:0] m, input logic [7:0] drop);
		req_out |= m;
		step();
		req_out &= ~(m | drop);
		static_out &= ~drop;
		step();
	endtask
endmodule

/* tb.sv */
// self-checking bench for the parameter bank selector
`timescale 1ns/1ps
module tb;
	import sbp_pkg::*;
	typedef struct packed {
		logic [7:0] act;
		logic [2:0] fail;
		logic [7:0] cur;
	} sbp_note_t;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [USED_W-1:0] used = 4'h8;
	logic rem = 1'b0;
	logic loc = 1'b0;
	logic [2:0] rem_bank = 3'h0;
	logic [2:0] loc_bank = 3'h0;
	logic force_en = 1'b0;
	logic [3:0] force_bank = 4'h0;
	logic [7:0] req, stat, active, en_on, en_off, req_on, req_off;
	logic [7:0] act_on, act_off;
	logic forced, valid;
	logic [31:0] stamp, last_s;
	logic [EV_W-1:0] misc_on, misc_off;
	logic [7:0] cur = 8'h01;
	logic [7:0] prev_act = 8'h01;
	logic [7:0] m;
	sbp_note_t notes[$];
	sbp_note_t n;
	int fail_count = 0;
	int checked = 0;
	int cyc = 0;
	int last_c = 0;
	always #20 clk = ~clk;
	sbp_req_src sbp_req_src_i (.clk_in(clk), .req_out(req),
		.static_out(stat));
	sbp_bank_select sbp_bank_select_i (.CLK_IN(clk), .RST_IN(rst),
		.BANK_REQ_IN(req), .BANK_STATIC_IN(stat), .USED_BANKS_IN(used),
		.REMOTE_REQ_IN(rem), .REMOTE_BANK_IN(rem_bank),
		.LOCAL_REQ_IN(loc), .LOCAL_BANK_IN(loc_bank),
		.FORCE_EN_IN(force_en), .FORCE_BANK_IN(force_bank),
		.ACTIVE_BANK_OUT(active), .FORCED_OUT(forced),
		.EVT_VALID_OUT(valid), .EVT_STAMP_OUT(stamp),
		.EVT_EN_ON_OUT(en_on), .EVT_EN_OFF_OUT(en_off),
		.EVT_REQ_ON_OUT(req_on), .EVT_REQ_OFF_OUT(req_off),
		.EVT_ACT_ON_OUT(act_on), .EVT_ACT_OFF_OUT(act_off),
		.EVT_MISC_ON_OUT(misc_on), .EVT_MISC_OFF_OUT(misc_off));
	// ==========================================
	// compare and report
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
		input string what);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic note_act(input logic [7:0] b);
		notes.push_back({b, 3'h0, b});
		cur = b;
	endtask
	task automatic note_fail(input logic [2:0] f);
		notes.push_back({8'h00, f, cur});
	endtask
	task automatic done(input string name);
		for (int i = 0; i < 20 && notes.size() > 0; i++) begin
			sbp_req_src_i.step();
		end
		if (notes.size() > 0) begin
			chk(notes.size(), 32'h0, "pending events");
			summarize();
		end else begin
			$display("test %s done", name);
		end
	endtask
	// ==========================================
	// monitor: every activation or failure event consumes one note
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (act_on !== 8'h00 || misc_on[5:3] !== 3'h0) begin
			if (notes.size() == 0) begin
				chk(32'h1, 32'h0, "spare event");
			end else begin
				n = notes.pop_front();
				chk(act_on, n.act, "act_on");
				chk(misc_on[5:3], n.fail, "fail_on");
				chk(active, n.cur, "active");
				chk(act_off, (n.act != 8'h00) ? prev_act : 8'h00,
					"act_off");
				prev_act = n.cur;
				chk(valid, 32'h1, "valid");
				if (last_c != 0) begin
					chk(stamp - last_s, cyc - last_c, "stamp");
				end
				last_s = stamp;
				last_c = cyc;
			end
		end
	end
	// ==========================================
	// scenarios
	initial begin
		void'($urandom(32'h780A));
		repeat (6) @(posedge clk);
		#1 rst = 1'b0;
		repeat (3) sbp_req_src_i.step();
		note_act(8'h08);
		sbp_req_src_i.pulse(8'h08, 8'h00);
		chk(req_off, 8'h08, "req_off");
		repeat (3) sbp_req_src_i.step();
		chk(active, 8'h08, "held");
		done("pulse");
		note_act(8'h04);
		sbp_req_src_i.pulse(8'h54, 8'h00);
		done("same cycle");
		sbp_req_src_i.hold(8'h02, 1'b1);
		note_act(8'h02);
		repeat (2) sbp_req_src_i.step();
		note_fail(3'h4);
		sbp_req_src_i.pulse(8'h10, 8'h00);
		chk(misc_off[5:3], 3'h4, "fail_off");
		note_act(8'h01);
		note_act(8'h02);
		sbp_req_src_i.pulse(8'h01, 8'h00);
		sbp_req_src_i.hold(8'h02, 1'b0);
		done("static middle");
		sbp_req_src_i.hold(8'h01, 1'b1);
		note_act(8'h01);
		sbp_req_src_i.step();
		chk(req_on, 8'h01, "req_on");
		sbp_req_src_i.step();
		note_fail(3'h4);
		sbp_req_src_i.pulse(8'h04, 8'h01);
		done("static first");
		sbp_req_src_i.hold(8'h80, 1'b1);
		note_act(8'h80);
		repeat (2) sbp_req_src_i.step();
		note_act(8'h20);
		sbp_req_src_i.pulse(8'h20, 8'h80);
		done("static last");
		used = 4'h4;
		note_act(8'h01);
		sbp_req_src_i.step();
		chk(en_off, 8'hF0, "en_off");
		note_fail(3'h1);
		sbp_req_src_i.pulse(8'h20, 8'h00);
		chk(misc_off[5:3], 3'h1, "fail_off");
		used = 4'h8;
		sbp_req_src_i.step();
		chk(en_on, 8'hF0, "en_on");
		done("unconfigured");
		force_en = 1'b1;
		force_bank = 4'h3;
		note_act(8'h04);
		sbp_req_src_i.step();
		chk(forced, 32'h1, "forced");
		chk(misc_on[EV_FORCE], 32'h1, "force_on");
		sbp_req_src_i.step();
		note_fail(3'h2);
		sbp_req_src_i.pulse(8'h02, 8'h00);
		chk(misc_off[5:3], 3'h2, "fail_off");
		// forced target beyond the configured count is refused
		note_fail(3'h1);
		force_bank = 4'h9;
		sbp_req_src_i.step();
		force_bank = 4'h0;
		force_en = 1'b0;
		repeat (2) sbp_req_src_i.step();
		chk(active, 8'h04, "after force");
		done("force");
		rem_bank = 3'h4;
		rem = 1'b1;
		note_act(8'h10);
		sbp_req_src_i.step();
		rem = 1'b0;
		loc_bank = 3'h6;
		loc = 1'b1;
		note_act(8'h40);
		chk(misc_on[EV_REMOTE], 32'h1, "remote_on");
		sbp_req_src_i.step();
		loc = 1'b0;
		chk(misc_off[EV_REMOTE], 32'h1, "remote_off");
		chk(misc_on[EV_LOCAL], 32'h1, "local_on");
		sbp_req_src_i.step();
		chk(misc_off[EV_LOCAL], 32'h1, "local_off");
		done("remote local");
		for (int i = 0; i < 8; i++) begin
			m = 8'h01 << ($urandom % 8);
			if (m != cur) begin
				note_act(m);
			end
			sbp_req_src_i.pulse(m, 8'h00);
		end
		done("random");
		summarize();
	end
endmodule
